// [include/pipe_pkg.sv]
// Shared constants for the PIPE control and status pair (PHY end and MAC end).
// Assumes a single 125 MHz clock in both ends; all timing counts derive from it.
package pipe_pkg;
    // Clock period and derived cycle counts (least times round up)
    localparam int CLK_PS = 8000;
    localparam int DETECT_NS = 400;
    localparam int DETECT_CYC = (DETECT_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int PWR_NS = 80;
    localparam int PWR_CYC = (PWR_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int INFER_NS = 128;
    localparam int INFER_CYC = (INFER_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CNT_W = 8;
    localparam int INFER_W = 12;

    // Power state encodings
    localparam logic [1:0] PWR_P0 = 2'h0;
    localparam logic [1:0] PWR_P0S = 2'h1;
    localparam logic [1:0] PWR_P1 = 2'h2;
    localparam logic [1:0] PWR_P2 = 2'h3;

    // Receiver status encodings
    localparam logic [2:0] ST_OK = 3'h0;
    localparam logic [2:0] ST_SKP_ADD = 3'h1;
    localparam logic [2:0] ST_SKP_DEL = 3'h2;
    localparam logic [2:0] ST_RCVR_DET = 3'h3;
    localparam logic [2:0] ST_DEC_ERR = 3'h4;
    localparam logic [2:0] ST_EB_OVF = 3'h5;
    localparam logic [2:0] ST_EB_UNF = 3'h6;
    localparam logic [2:0] ST_DISP_ERR = 3'h7;

    // PHY sequencer states
    typedef enum logic [1:0] {
        PHY_IDLE = 2'b00,
        PHY_DETECT = 2'b01,
        PHY_PWR = 2'b10,
        PHY_WAIT = 2'b11
    } phy_state_t;

    // MAC register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ = 8'h0C;
    localparam logic [7:0] REG_MASK = 8'h10;
    localparam logic [7:0] CTRL_RST = 8'h06;
    localparam int CTRL_IDLE_BIT = 2;
    localparam int CTRL_SEL_LSB = 3;
    localparam int CTRL_INV_BIT = 6;
    localparam int CTRL_LOOP_BIT = 7;
    localparam int CMD_DETECT_BIT = 0;
    localparam int CMD_COMPL_BIT = 1;
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_RXDET = 1;
    localparam int IRQ_RXERR = 2;
    localparam int IRQ_IDLE = 3;
endpackage

// [include/pipe_if.sv]
// PIPE control/status wires between the MAC end and the PHY end.
// Plain point-to-point wires, all synchronous to the common clock.
`timescale 1ns/1ps
`default_nettype none
interface pipe_if;
    logic detect_loop;
    logic force_elec_idle;
    logic compliance_neg_disp_force;
    logic decoder_polarity_invert;
    logic [1:0] power_down;
    logic [2:0] infer_sel;
    logic data_valid;
    logic [7:0] rx_data;
    logic rx_ctrl;
    logic phy_done;
    logic rx_elec_idle;
    logic [2:0] rx_status;

    modport dev (
        input detect_loop, force_elec_idle, compliance_neg_disp_force,
        input decoder_polarity_invert, power_down, infer_sel,
        output data_valid, rx_data, rx_ctrl, phy_done, rx_elec_idle, rx_status
    );
    modport mac (
        output detect_loop, force_elec_idle, compliance_neg_disp_force,
        output decoder_polarity_invert, power_down, infer_sel,
        input data_valid, rx_data, rx_ctrl, phy_done, rx_elec_idle, rx_status
    );
endinterface
`default_nettype wire

// [hdl/idle_infer.sv]
// Electrical idle inference: flags idle after a run of cycles with no activity.
// Assumes activity is a one-cycle-per-symbol strobe on the common clock.
`timescale 1ns/1ps
`default_nettype none
module idle_infer #(
    parameter int W = 12
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Control and observation
    input wire logic enable,
    input wire logic activity,
    input wire logic [W-1:0] limit,
    // Result
    output logic idle
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic idle;
    } inf_st_t;

    inf_st_t s_r;
    inf_st_t s_nxt;

    // Silence counter; saturates so a long gap never wraps back to busy
    always_comb begin
        s_nxt = s_r;
        if (!enable || activity) begin
            s_nxt.cnt = '0;
            s_nxt.idle = 1'b0;
        end else if (s_r.cnt >= limit) begin
            s_nxt.idle = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + W'(1);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign idle = s_r.idle;
endmodule
`default_nettype wire

// [hdl/pipe_phy_dev.sv]
// PHY end of the PIPE control/status path: power state, receiver detect,
// loopback steering, compliance disparity, polarity and receive status.
// Assumes the datapath (encoder, decoder, elastic buffer, detect analog)
// sits outside and runs on the same 125 MHz clock.
//
// Added by the designer: the signal threshold comparator and inferred electrical idle.
`timescale 1ns/1ps
`default_nettype none
module pipe_phy_dev #(
    parameter int LVL_W = 8,
    parameter logic [LVL_W-1:0] SIG_THRESH = 8'h40
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // PIPE side
    pipe_if.dev pipe,
    // Receive decoder side
    input wire logic [9:0] rx_sym,
    input wire logic dec_valid,
    input wire logic [7:0] dec_data,
    input wire logic dec_ctrl,
    input wire logic dec_err,
    input wire logic disp_err,
    input wire logic eb_overflow,
    input wire logic eb_underflow,
    input wire logic skp_added,
    input wire logic skp_removed,
    output logic [9:0] dec_sym,
    // Analog front end
    input wire logic [LVL_W-1:0] rx_level,
    input wire logic rx_present,
    output logic det_start,
    // Transmit and channel steering
    output logic enc_force_neg_disp,
    output logic rev_loopback,
    output logic [1:0] pwr_state
);
    typedef struct packed {
        pipe_pkg::phy_state_t st;
        logic [pipe_pkg::CNT_W-1:0] cnt;
        logic [1:0] pwr;
        logic done;
        logic det_start;
        logic [2:0] status;
        logic valid;
        logic [7:0] data;
        logic ctrl;
        logic elec_idle;
        logic loop;
        logic neg_disp;
        logic [9:0] sym;
    } dev_st_t;

    localparam logic [pipe_pkg::CNT_W-1:0] DET_LOAD =
        pipe_pkg::CNT_W'(pipe_pkg::DETECT_CYC - 1);
    localparam logic [pipe_pkg::CNT_W-1:0] PWR_LOAD =
        pipe_pkg::CNT_W'(pipe_pkg::PWR_CYC - 1);
    localparam logic [pipe_pkg::INFER_W-1:0] INFER_BASE =
        pipe_pkg::INFER_W'(pipe_pkg::INFER_CYC);

    dev_st_t s_r;
    dev_st_t s_nxt;
    logic sig_detect;
    logic inferred_idle;
    logic infer_on;
    logic [2:0] err_status;
    logic [pipe_pkg::INFER_W-1:0] infer_limit;

    // Comparator against the programmed detection threshold
    assign sig_detect = rx_level > SIG_THRESH;

    // Select zero means inference off; others stretch the silence window
    assign infer_on = pipe.infer_sel != 3'h0;
    assign infer_limit = INFER_BASE << pipe.infer_sel;

    idle_infer #(
        .W(pipe_pkg::INFER_W)
    ) u_infer (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .enable(infer_on),
        .activity(dec_valid),
        .limit(infer_limit),
        .idle(inferred_idle)
    );

    // Per-symbol status; errors outrank buffer events, which outrank skips
    always_comb begin
        if (disp_err) begin
            err_status = pipe_pkg::ST_DISP_ERR;
        end else if (dec_err) begin
            err_status = pipe_pkg::ST_DEC_ERR;
        end else if (eb_overflow) begin
            err_status = pipe_pkg::ST_EB_OVF;
        end else if (eb_underflow) begin
            err_status = pipe_pkg::ST_EB_UNF;
        end else if (skp_added) begin
            err_status = pipe_pkg::ST_SKP_ADD;
        end else if (skp_removed) begin
            err_status = pipe_pkg::ST_SKP_DEL;
        end else begin
            err_status = pipe_pkg::ST_OK;
        end
    end

    // Next state: datapath side-bands, then the detect/power sequencer
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.det_start = 1'b0;
        s_nxt.valid = dec_valid;
        s_nxt.data = dec_data;
        s_nxt.ctrl = dec_ctrl;
        s_nxt.status = err_status;
        s_nxt.sym = pipe.decoder_polarity_invert ? ~rx_sym : rx_sym;
        s_nxt.neg_disp = pipe.compliance_neg_disp_force;
        // Loopback follows the live request; it is a level, not a command
        s_nxt.loop = pipe.detect_loop && s_r.pwr == pipe_pkg::PWR_P0
            && !pipe.force_elec_idle;
        s_nxt.elec_idle = infer_on ? inferred_idle : !sig_detect;
        unique case (s_r.st)
            pipe_pkg::PHY_IDLE: begin
                if (pipe.power_down != s_r.pwr) begin
                    // Power change takes precedence over a pending detect
                    s_nxt.pwr = pipe.power_down;
                    s_nxt.cnt = PWR_LOAD;
                    s_nxt.st = pipe_pkg::PHY_PWR;
                end else if (pipe.detect_loop && s_r.pwr == pipe_pkg::PWR_P1
                    && pipe.force_elec_idle) begin
                    s_nxt.cnt = DET_LOAD;
                    s_nxt.det_start = 1'b1;
                    s_nxt.st = pipe_pkg::PHY_DETECT;
                end
            end
            pipe_pkg::PHY_DETECT: begin
                if (s_r.cnt == '0) begin
                    s_nxt.done = 1'b1;
                    // Result shares the cycle of the completion pulse
                    s_nxt.status = rx_present ? pipe_pkg::ST_RCVR_DET
                        : pipe_pkg::ST_OK;
                    s_nxt.st = pipe_pkg::PHY_WAIT;
                end else begin
                    s_nxt.cnt = s_r.cnt - pipe_pkg::CNT_W'(1);
                end
            end
            pipe_pkg::PHY_PWR: begin
                if (s_r.cnt == '0) begin
                    s_nxt.done = 1'b1;
                    s_nxt.st = pipe_pkg::PHY_IDLE;
                end else begin
                    s_nxt.cnt = s_r.cnt - pipe_pkg::CNT_W'(1);
                end
            end
            pipe_pkg::PHY_WAIT: begin
                // No re-trigger until the request is dropped
                if (!pipe.detect_loop) begin
                    s_nxt.st = pipe_pkg::PHY_IDLE;
                end
            end
        endcase
    end

    // State register; resets into P1 with the link idle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.pwr <= pipe_pkg::PWR_P1;
            s_r.elec_idle <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign pipe.data_valid = s_r.valid;
    assign pipe.rx_data = s_r.data;
    assign pipe.rx_ctrl = s_r.ctrl;
    assign pipe.phy_done = s_r.done;
    assign pipe.rx_elec_idle = s_r.elec_idle;
    assign pipe.rx_status = s_r.status;
    assign dec_sym = s_r.sym;
    assign det_start = s_r.det_start;
    assign enc_force_neg_disp = s_r.neg_disp;
    assign rev_loopback = s_r.loop;
    assign pwr_state = s_r.pwr;
endmodule
`default_nettype wire

// [hdl/pipe_mac_ctrl.sv]
// MAC end of the PIPE control/status path, run by software through a
// small register port. Assumes the PHY end shares the 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module pipe_mac_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq,
    // PIPE side
    pipe_if.mac pipe
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic det_pend;
        logic det_found;
        logic dl;
        logic compl;
        logic idle_q;
        logic [2:0] last_status;
        logic [pipe_pkg::IRQ_W-1:0] irq_st;
        logic [pipe_pkg::IRQ_W-1:0] mask;
        logic irq;
        logic [31:0] rdata;
    } mac_st_t;

    mac_st_t s_r;
    mac_st_t s_nxt;
    logic [pipe_pkg::IRQ_W-1:0] ev;
    logic [pipe_pkg::IRQ_W-1:0] clr;
    logic p1_idle;

    assign p1_idle = s_r.ctrl[1:0] == pipe_pkg::PWR_P1 && s_r.ctrl[pipe_pkg::CTRL_IDLE_BIT];

    // Events seen on the PIPE outputs
    always_comb begin
        ev = '0;
        ev[pipe_pkg::IRQ_DONE] = pipe.phy_done;
        ev[pipe_pkg::IRQ_RXDET] = pipe.phy_done && pipe.rx_status == pipe_pkg::ST_RCVR_DET;
        ev[pipe_pkg::IRQ_RXERR] = pipe.rx_status[2];
        ev[pipe_pkg::IRQ_IDLE] = pipe.rx_elec_idle && !s_r.idle_q;
        clr = (wr && addr == pipe_pkg::REG_IRQ) ? wdata[pipe_pkg::IRQ_W-1:0] : '0;
    end

    // Register writes, reads and the detect handshake
    always_comb begin
        s_nxt = s_r;
        s_nxt.compl = 1'b0;
        s_nxt.rdata = '0;
        s_nxt.idle_q = pipe.rx_elec_idle;
        if (pipe.rx_status != pipe_pkg::ST_OK) begin
            s_nxt.last_status = pipe.rx_status;
        end
        if (wr) begin
            unique case (addr)
                pipe_pkg::REG_CTRL: s_nxt.ctrl = wdata[7:0];
                pipe_pkg::REG_MASK: s_nxt.mask = wdata[pipe_pkg::IRQ_W-1:0];
                pipe_pkg::REG_CMD: begin
                    // Detect only makes sense in P1 with idle forced
                    if (wdata[pipe_pkg::CMD_DETECT_BIT] && p1_idle && !s_r.det_pend) begin
                        s_nxt.det_pend = 1'b1;
                    end
                    // One cycle covers the single leading compliance byte
                    s_nxt.compl = wdata[pipe_pkg::CMD_COMPL_BIT];
                end
                default: begin
                end
            endcase
        end
        if (rd) begin
            unique case (addr)
                pipe_pkg::REG_CTRL: s_nxt.rdata = {24'h000000, s_r.ctrl};
                pipe_pkg::REG_STAT: s_nxt.rdata = {26'h0000000, s_r.last_status,
                    s_r.idle_q, s_r.det_found, s_r.det_pend};
                pipe_pkg::REG_IRQ: s_nxt.rdata = {28'h0000000, s_r.irq_st};
                pipe_pkg::REG_MASK: s_nxt.rdata = {28'h0000000, s_r.mask};
                default: s_nxt.rdata = '0;
            endcase
        end
        // Completion ends the pending detect and drops the request
        if (s_r.det_pend && pipe.phy_done) begin
            s_nxt.det_pend = 1'b0;
            s_nxt.det_found = pipe.rx_status == pipe_pkg::ST_RCVR_DET;
        end
        // Same wire carries loopback request in P0 with idle released
        s_nxt.dl = s_nxt.det_pend || (s_nxt.ctrl[pipe_pkg::CTRL_LOOP_BIT]
            && s_nxt.ctrl[1:0] == pipe_pkg::PWR_P0
            && !s_nxt.ctrl[pipe_pkg::CTRL_IDLE_BIT]);
        // Set wins over a write-one clear in the same cycle
        s_nxt.irq_st = (s_r.irq_st & ~clr) | ev;
        s_nxt.irq = |(s_nxt.irq_st & s_nxt.mask);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.ctrl <= pipe_pkg::CTRL_RST;
            s_r.idle_q <= 1'b1; // PHY resets idle high; avoids a false idle edge
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs from flip-flops
    assign rdata = s_r.rdata;
    assign irq = s_r.irq;
    assign pipe.detect_loop = s_r.dl;
    assign pipe.compliance_neg_disp_force = s_r.compl;
    assign pipe.power_down = s_r.ctrl[1:0];
    assign pipe.force_elec_idle = s_r.ctrl[pipe_pkg::CTRL_IDLE_BIT];
    assign pipe.infer_sel = s_r.ctrl[pipe_pkg::CTRL_SEL_LSB +: 3];
    assign pipe.decoder_polarity_invert = s_r.ctrl[pipe_pkg::CTRL_INV_BIT];
endmodule
`default_nettype wire

// [tb/pipe_if_asserts.sv]
// Concurrent checks on the PIPE wires between the MAC end and the PHY end.
// Assumes one clock domain; instantiated beside the interface in tb_top.
`timescale 1ns/1ps
`default_nettype none
module pipe_if_asserts (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // MAC-driven wires
    input wire logic detect_loop,
    input wire logic force_elec_idle,
    input wire logic compliance_neg_disp_force,
    input wire logic [1:0] power_down,
    input wire logic [2:0] infer_sel,
    // PHY-driven wires
    input wire logic data_valid,
    input wire logic phy_done,
    input wire logic rx_elec_idle,
    input wire logic [2:0] rx_status
);
    // One cycle of slack either side, the count origin is ambiguous
    localparam int DET_LO = pipe_pkg::DETECT_CYC - 1;
    localparam int DET_HI = pipe_pkg::DETECT_CYC + 1;
    localparam int PWR_LO = pipe_pkg::PWR_CYC - 1;
    localparam int PWR_HI = pipe_pkg::PWR_CYC + 1;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Completion and compliance force are single-cycle
    property p_done_pulse;
        phy_done |=> !phy_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
    property p_compl_pulse;
        compliance_neg_disp_force |=> !compliance_neg_disp_force;
    endproperty
    a_compl_pulse: assert property (p_compl_pulse) else $error("force held too long");
    // Detect in P1 with idle forced finishes after the detect time
    property p_det_done;
        $rose(detect_loop) && force_elec_idle && power_down == pipe_pkg::PWR_P1
            |-> ##[DET_LO:DET_HI] phy_done;
    endproperty
    a_det_done: assert property (p_det_done) else $error("detect did not complete");
    // Loopback request must not start a detection
    property p_loop_no_det;
        $rose(detect_loop) && !force_elec_idle && power_down == pipe_pkg::PWR_P0
            |=> !phy_done [*6];
    endproperty
    a_loop_no_det: assert property (p_loop_no_det) else $error("loopback gave done");
    // Power change completes after the settle time
    property p_pwr_done;
        $changed(power_down) |-> ##[PWR_LO:PWR_HI] phy_done;
    endproperty
    a_pwr_done: assert property (p_pwr_done) else $error("power change not done");
    // Detect request released right after its completion
    property p_det_drop;
        phy_done && detect_loop && force_elec_idle |=> !detect_loop;
    endproperty
    a_det_drop: assert property (p_det_drop) else $error("detect not dropped");
    // Receiver-detected code only rides with completion
    property p_det_code;
        rx_status == pipe_pkg::ST_RCVR_DET |-> phy_done;
    endproperty
    a_det_code: assert property (p_det_code) else $error("detected code off done");
    // Inferred idle only after a quiet stretch
    property p_infer_idle;
        infer_sel != 3'h0 && $rose(rx_elec_idle) |-> !data_valid && !$past(data_valid);
    endproperty
    a_infer_idle: assert property (p_infer_idle) else $error("idle during traffic");
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Testbench: MAC end and PHY end joined by the PIPE interface.
// Assumes one 125 MHz clock; software side driven through the register port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk;
    logic sys_rst;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic irq;
    logic [9:0] rx_sym;
    logic dec_valid;
    logic [7:0] dec_data;
    logic dec_ctrl;
    logic [5:0] ev;
    logic [7:0] rx_level;
    logic rx_present;
    logic [9:0] dec_sym;
    logic det_start;
    logic enc_force_neg_disp;
    logic rev_loopback;
    logic [1:0] pwr_state;
    logic [31:0] d;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;

    // Both ends and the checker on the shared wires
    pipe_if pipe_if_inst ();
    pipe_mac_ctrl pipe_mac_ctrl_inst (.mclk(mclk), .sys_rst(sys_rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .pipe(pipe_if_inst));
    pipe_phy_dev pipe_phy_dev_inst (.mclk(mclk), .sys_rst(sys_rst), .pipe(pipe_if_inst),
        .rx_sym(rx_sym), .dec_valid(dec_valid), .dec_data(dec_data), .dec_ctrl(dec_ctrl),
        .skp_added(ev[0]), .skp_removed(ev[1]), .dec_err(ev[2]), .eb_overflow(ev[3]),
        .eb_underflow(ev[4]), .disp_err(ev[5]), .dec_sym(dec_sym), .rx_level(rx_level),
        .rx_present(rx_present), .det_start(det_start),
        .enc_force_neg_disp(enc_force_neg_disp), .rev_loopback(rev_loopback),
        .pwr_state(pwr_state));
    pipe_if_asserts pipe_if_asserts_inst (.mclk(mclk), .sys_rst(sys_rst),
        .detect_loop(pipe_if_inst.detect_loop), .force_elec_idle(pipe_if_inst.force_elec_idle),
        .compliance_neg_disp_force(pipe_if_inst.compliance_neg_disp_force),
        .power_down(pipe_if_inst.power_down), .infer_sel(pipe_if_inst.infer_sel),
        .data_valid(pipe_if_inst.data_valid), .phy_done(pipe_if_inst.phy_done),
        .rx_elec_idle(pipe_if_inst.rx_elec_idle), .rx_status(pipe_if_inst.rx_status));

    // Clock, 8 ns period
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Single-cycle register strobes; read data taken in the following cycle
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Bounded wait for completion; n holds the cycles waited
    task automatic wait_done();
        n = 0;
        #1;
        while (pipe_if_inst.phy_done !== 1'b1 && n < 300) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("done_seen", 1, n < 300);
    endtask

    task automatic t_reset();
        @(posedge mclk);
        #1 chk("rst_pwr", 2'h2, pwr_state);
        chk("rst_status", 3'h0, pipe_if_inst.rx_status);
        chk("rst_irq", 0, irq);
        rd_reg(pipe_pkg::REG_CTRL);
        chk("rst_ctrl", 32'h06, d);
        rd_reg(8'hFC);
        chk("unmapped", 0, d);
        rd_reg(pipe_pkg::REG_IRQ);
        chk("rst_irq_st", 0, d);
    endtask

    task automatic t_idle();
        @(posedge mclk) rx_level <= 8'h41;
        repeat (2) @(posedge mclk);
        #1 chk("idle_sig", 0, pipe_if_inst.rx_elec_idle);
        @(posedge mclk) rx_level <= 8'h40;
        repeat (2) @(posedge mclk);
        #1 chk("idle_thr", 1, pipe_if_inst.rx_elec_idle);
        @(posedge mclk) rx_level <= 8'h41;
        dec_valid <= 1'b1;
        wr_reg(pipe_pkg::REG_CTRL, 32'h0E);
        repeat (3) @(posedge mclk);
        dec_valid <= 1'b0;
        #1 chk("idle_busy", 0, pipe_if_inst.rx_elec_idle);
        n = 0;
        while (pipe_if_inst.rx_elec_idle !== 1'b1 && n < 200) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("infer_win", 1, n >= 30 && n <= 36);
        wr_reg(pipe_pkg::REG_CTRL, 32'h06);
    endtask

    task automatic t_status();
        logic [2:0] code [7] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7};
        for (int i = 0; i < 7; i++) begin
            @(posedge mclk);
            ev <= (i < 6) ? 6'h01 << i : 6'h3F;
            dec_valid <= 1'b1;
            dec_data <= 8'(i);
            dec_ctrl <= i[0];
            @(posedge mclk);
            ev <= 6'h00;
            dec_valid <= 1'b0;
            #1 chk("status", code[i], pipe_if_inst.rx_status);
            chk("rx_data", 8'(i), pipe_if_inst.rx_data);
            chk("rx_ctrl", i[0], pipe_if_inst.rx_ctrl);
            chk("valid_on", 1, pipe_if_inst.data_valid);
        end
        @(posedge mclk);
        #1 chk("status_ok", 3'h0, pipe_if_inst.rx_status);
        chk("valid_off", 0, pipe_if_inst.data_valid);
        rd_reg(pipe_pkg::REG_IRQ);
        chk("irq_rxerr", 1, d[pipe_pkg::IRQ_RXERR]);
        wr_reg(pipe_pkg::REG_IRQ, 32'hF);
    endtask

    task automatic t_polarity();
        rx_sym <= 10'h2A5;
        wr_reg(pipe_pkg::REG_CTRL, 32'h46);
        repeat (2) @(posedge mclk);
        #1 chk("sym_inv", 10'h15A, dec_sym);
        wr_reg(pipe_pkg::REG_CTRL, 32'h06);
        repeat (2) @(posedge mclk);
        #1 chk("sym_pass", 10'h2A5, dec_sym);
    endtask

    task automatic t_power();
        logic [1:0] seq [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        for (int i = 0; i < 4; i++) begin
            wr_reg(pipe_pkg::REG_CTRL, {29'h0, 1'b1, seq[i]});
            wait_done();
            chk("pwr_state", seq[i], pwr_state);
        end
    endtask

    task automatic t_loop();
        wr_reg(pipe_pkg::REG_CTRL, 32'h80);
        wait_done();
        repeat (2) @(posedge mclk);
        #1 chk("loop_on", 1, rev_loopback);
        wr_reg(pipe_pkg::REG_CTRL, 32'h84);
        repeat (2) @(posedge mclk);
        #1 chk("loop_off", 0, rev_loopback);
        wr_reg(pipe_pkg::REG_CTRL, 32'h06);
        wait_done();
    endtask

    // Detect with the receiver-detected interrupt unmasked
    task automatic t_detect(input logic pres);
        @(posedge mclk) rx_present <= pres;
        wr_reg(pipe_pkg::REG_MASK, 32'h2);
        wr_reg(pipe_pkg::REG_CMD, 32'h1);
        @(posedge mclk);
        #1 chk("det_start", 1, det_start);
        wait_done();
        chk("det_lat", 1, n >= 48 && n <= 52);
        chk("det_code", pres ? 3'h3 : 3'h0, pipe_if_inst.rx_status);
        repeat (3) @(posedge mclk);
        #1 chk("irq_out", pres, irq);
        chk("det_drop", 0, pipe_if_inst.detect_loop);
        rd_reg(pipe_pkg::REG_IRQ);
        chk("irq_bits", {pres, 1'b1}, d[1:0]);
        rd_reg(pipe_pkg::REG_STAT);
        chk("stat_found", {pres, 1'b0}, d[1:0]);
        chk("stat_last", 3'h3, d[5:3]);
        wr_reg(pipe_pkg::REG_IRQ, 32'hF);
        @(posedge mclk);
        #1 chk("irq_clr", 0, irq);
    endtask

    task automatic t_compl();
        int cnt;
        cnt = 0;
        wr_reg(pipe_pkg::REG_CMD, 32'h2);
        repeat (4) begin
            @(posedge mclk);
            #1 cnt += enc_force_neg_disp;
        end
        chk("force_cnt", 1, cnt);
    endtask

    // Main sequence after 5 cycles of reset
    initial begin
        sys_rst = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        rx_sym = 10'h000;
        dec_valid = 1'b0;
        dec_data = 8'h00;
        dec_ctrl = 1'b0;
        ev = 6'h00;
        rx_level = 8'h00;
        rx_present = 1'b0;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_idle();
        t_status();
        t_polarity();
        t_power();
        t_loop();
        t_detect(1'b1);
        t_detect(1'b0);
        t_compl();
        tally_and_finish();
    end
endmodule
`default_nettype wire
